// ==== src/hrr_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the
//          headphone output routing register bank
// Assumes: page 0 register indices, 8-bit registers
// Notes:   definitions only
`ifndef HRR_CONSTS_SVH
`define HRR_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices, page 0
// ----------------------------------------------------------------------
`define HRR_IDX_RDAC_TO_COM   7'h39
`define HRR_IDX_COM_LEVEL     7'h3A
`define HRR_IDX_LAUX_TO_RHP   7'h3B
`define HRR_IDX_LAMP_TO_RHP   7'h3C
`define HRR_IDX_LDAC_TO_RHP   7'h3D
`define HRR_IDX_RAUX_TO_RHP   7'h3E
`define HRR_IDX_RAMP_TO_RHP   7'h3F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define HRR_ROUTE_EN_BIT      7
`define HRR_VOL_MSB           6
`define HRR_VOL_LSB           0
`define HRR_LVL_MSB           7
`define HRR_LVL_LSB           4
`define HRR_UNMUTE_BIT        3
`define HRR_PD_HIZ_BIT        2
`define HRR_PENDING_BIT       1
`define HRR_POWER_BIT         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define HRR_ROUTE_RST         8'h00
`define HRR_LEVEL_CTRL_RST    8'h04
`define HRR_RDATA_RST         8'h00
`define HRR_LVL_MAX_CODE      4'h9

// ----------------------------------------------------------------------
// timing: one gain step per step time
// ----------------------------------------------------------------------
`define HRR_CLK_MHZ           50
`define HRR_STEP_TIME_US      20
`define HRR_STEP_CYCLES       (`HRR_STEP_TIME_US * `HRR_CLK_MHZ)

`endif

// ==== src/hrr_pkg.sv ====
// Purpose: shared types of the headphone output routing register bank
// Assumes: hrr_consts.svh holds all numbers
// Notes:   none
package hrr_pkg;

    typedef logic [4:0][6:0] hrr_vol_t;

    // slot 0 is right dac to common, slots 1..5 are the right output routings
    typedef struct packed {
        logic [5:0][7:0] route;
        logic [7:0]      ctrl;
        logic [7:0]      rdata;
        logic [15:0]     tick_cnt;
    } hrr_regs_s;

endpackage

// ==== src/hrr_step_if.sv ====
// Purpose: carries one gain target to a stepper and its applied value back
// Assumes: single clock
// Notes:   busy is high while applied has not reached target
`timescale 1ns/1ps
interface hrr_step_if #(
    parameter int W = 4
);
    logic [W-1:0] target;
    logic [W-1:0] applied;
    logic         busy;

    modport ramp (input target, output applied, output busy);
    modport ctrl (output target, input applied, input busy);
endinterface

// ==== src/hrr_gain_step.sv ====
// Purpose: walks an applied gain code one step per tick toward its target
// Assumes: tick is a one-cycle pulse from the same clock
// Notes:   busy stays high after reset until the first tick
`timescale 1ns/1ps
module hrr_gain_step #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // step pacing
    input  wire logic tick,
    // target in, applied out
    hrr_step_if.ramp  step
);
    typedef struct packed {
        logic [W-1:0] cur;
        logic         init;
    } hrr_step_s;

    hrr_step_s st_q;
    hrr_step_s st_d;

    always_comb begin
        st_d = st_q;
        if (tick) begin
            st_d.init = 1'b0;
            if (st_q.cur < step.target) begin
                st_d.cur = st_q.cur + W'(1);
            end else if (st_q.cur > step.target) begin
                st_d.cur = st_q.cur - W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q.cur  <= '0;
            st_q.init <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign step.applied = st_q.cur;
    assign step.busy    = st_q.init | (st_q.cur != step.target);
endmodule

// ==== src/hrr_headphone_regs.sv ====
// Purpose: page 0 register bank for common and right headphone output routing
// Assumes: register port driven by control-bus logic on the same clock
// Notes:   common output gain codes reach the analog side through slow steppers; right output volumes go straight out
//
// What this block does
// - bit 7 of each routing register connects its source; resets to 0.
// - bits 6..0 of each routing register hold a read/write volume code, reset zero.
// - common output level bits 7..4 give 0..9 dB in 1 dB steps, reset 0.
// - common output unmute bit 3 is 0 after reset, output starts muted.
// - bit 2 picks powered-down drive: 0 weak common-mode, 1 high impedance; resets 1.
// - read-only bit 1 is 1 while common output gains are pending; 1 after reset.
// - bit 0 powers up the common output fully; resets to 0.
// - right dac to common at 57, level at 58, right output routings 59..63.
`timescale 1ns/1ps
`include "hrr_consts.svh"
module hrr_headphone_regs import hrr_pkg::*; #(
    parameter logic [15:0] STEP_CYCLES = 16'(`HRR_STEP_CYCLES)
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // register port
    input  wire logic       reg_page0,
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // common headphone output controls
    output logic            rdac_to_common_en,
    output logic      [6:0] rdac_to_common_vol,
    output logic      [3:0] common_hp_level,
    output logic            common_hp_unmute,
    output logic            common_hp_pd_hiz,
    output logic            common_hp_power_up,
    output logic            common_hp_pending,
    // right headphone output routings: left aux, left amp, left dac, right aux, right amp
    output logic      [4:0] right_hp_route_en,
    output hrr_vol_t        right_hp_vol
);
    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    hrr_regs_s r_q;
    hrr_regs_s r_d;
    logic      tick;
    logic      pending;
    logic      wr_hit;

    hrr_step_if #(.W(4)) lvl_if ();
    hrr_step_if #(.W(7)) vol_if ();

    assign wr_hit  = reg_wr & reg_page0;
    assign tick    = (r_q.tick_cnt == STEP_CYCLES - 16'h0001);
    assign pending = lvl_if.busy | vol_if.busy;

    // ----------------------------------------------------------------------
    // register writes, read mux, step pacing
    // ----------------------------------------------------------------------
    always_comb begin
        r_d          = r_q;
        r_d.tick_cnt = tick ? 16'h0000 : r_q.tick_cnt + 16'h0001;
        if (wr_hit) begin
            case (reg_addr)
                `HRR_IDX_RDAC_TO_COM: r_d.route[0] = reg_wdata;
                `HRR_IDX_LAUX_TO_RHP: r_d.route[1] = reg_wdata;
                `HRR_IDX_LAMP_TO_RHP: r_d.route[2] = reg_wdata;
                `HRR_IDX_LDAC_TO_RHP: r_d.route[3] = reg_wdata;
                `HRR_IDX_RAUX_TO_RHP: r_d.route[4] = reg_wdata;
                `HRR_IDX_RAMP_TO_RHP: r_d.route[5] = reg_wdata;
                `HRR_IDX_COM_LEVEL: begin
                    r_d.ctrl = reg_wdata;
                    // status bit is never stored, it always comes from the steppers
                    r_d.ctrl[`HRR_PENDING_BIT] = 1'b0;
                end
                default: r_d.ctrl = r_q.ctrl;
            endcase
        end
        // unmapped or other-page reads return zero
        r_d.rdata = 8'h00;
        if (reg_page0) begin
            case (reg_addr)
                `HRR_IDX_RDAC_TO_COM: r_d.rdata = r_q.route[0];
                `HRR_IDX_LAUX_TO_RHP: r_d.rdata = r_q.route[1];
                `HRR_IDX_LAMP_TO_RHP: r_d.rdata = r_q.route[2];
                `HRR_IDX_LDAC_TO_RHP: r_d.rdata = r_q.route[3];
                `HRR_IDX_RAUX_TO_RHP: r_d.rdata = r_q.route[4];
                `HRR_IDX_RAMP_TO_RHP: r_d.rdata = r_q.route[5];
                `HRR_IDX_COM_LEVEL: begin
                    r_d.rdata = r_q.ctrl;
                    r_d.rdata[`HRR_PENDING_BIT] = pending;
                end
                default: r_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r_q.route    <= {6{`HRR_ROUTE_RST}};
            r_q.ctrl     <= `HRR_LEVEL_CTRL_RST;
            r_q.rdata    <= `HRR_RDATA_RST;
            r_q.tick_cnt <= 16'h0000;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------------
    // gain steppers for the common output; avoids zipper noise on big jumps
    // ----------------------------------------------------------------------
    assign lvl_if.target = r_q.ctrl[`HRR_LVL_MSB:`HRR_LVL_LSB];
    assign vol_if.target = r_q.route[0][`HRR_VOL_MSB:`HRR_VOL_LSB];

    hrr_gain_step #(.W(4)) u_lvl_step (
        .clock (clock),
        .srst  (srst),
        .tick  (tick),
        .step  (lvl_if)
    );

    hrr_gain_step #(.W(7)) u_vol_step (
        .clock (clock),
        .srst  (srst),
        .tick  (tick),
        .step  (vol_if)
    );

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign reg_rdata          = r_q.rdata;
    assign rdac_to_common_en  = r_q.route[0][`HRR_ROUTE_EN_BIT];
    assign rdac_to_common_vol = vol_if.applied;
    assign common_hp_level    = lvl_if.applied;
    assign common_hp_unmute   = r_q.ctrl[`HRR_UNMUTE_BIT];
    assign common_hp_pd_hiz   = r_q.ctrl[`HRR_PD_HIZ_BIT];
    assign common_hp_power_up = r_q.ctrl[`HRR_POWER_BIT];
    assign common_hp_pending  = pending;

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            right_hp_route_en[i] = r_q.route[i+1][`HRR_ROUTE_EN_BIT];
            right_hp_vol[i]      = r_q.route[i+1][`HRR_VOL_MSB:`HRR_VOL_LSB];
        end
    end

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_route_reset: assert property (
        $past(srst) |-> (!rdac_to_common_en && right_hp_route_en == 5'h00))
        else $error("routing enable not clear after reset");

    chk_vol_write: assert property (
        (wr_hit && reg_addr == `HRR_IDX_LAUX_TO_RHP) |=>
            (right_hp_vol[0] == $past(reg_wdata[6:0])
             && right_hp_route_en[0] == $past(reg_wdata[7])))
        else $error("right output routing write not stored");

    chk_level_step: assert property (
        !tick |=> $stable(common_hp_level))
        else $error("common level moved without a step tick");

    chk_unmute_reset: assert property (
        $past(srst) |-> !common_hp_unmute)
        else $error("common output not muted after reset");

    chk_pd_hiz_reset: assert property (
        $past(srst) |-> (common_hp_pd_hiz && !common_hp_power_up))
        else $error("power-down drive or power bit wrong after reset");

    chk_pending_reset: assert property (
        $past(srst) |-> common_hp_pending ##1 (reg_rdata[1] || !$past(reg_page0)
            || $past(reg_addr) != `HRR_IDX_COM_LEVEL))
        else $error("pending status not set after reset");

    chk_pending_clear: assert property (
        !common_hp_pending |-> (common_hp_level == r_q.ctrl[`HRR_LVL_MSB:`HRR_LVL_LSB]
            && rdac_to_common_vol == r_q.route[0][`HRR_VOL_MSB:`HRR_VOL_LSB]))
        else $error("pending clear while gain not applied");

    chk_power_write: assert property (
        (wr_hit && reg_addr == `HRR_IDX_COM_LEVEL) |=>
            (common_hp_power_up == $past(reg_wdata[0])
             && common_hp_unmute == $past(reg_wdata[3])))
        else $error("common level register write not stored");

    chk_map_read: assert property (
        (reg_page0 && reg_addr == `HRR_IDX_RDAC_TO_COM && !wr_hit) |=>
            (reg_rdata == {rdac_to_common_en, vol_if.target}))
        else $error("register 57 readback wrong");

    chk_status_ro: assert property (
        (reg_page0 && reg_addr == `HRR_IDX_COM_LEVEL) |=>
            (reg_rdata[1] == $past(pending)))
        else $error("status bit readback not from steppers");

    chk_route_en_write: assert property (
        (wr_hit && reg_addr == `HRR_IDX_RDAC_TO_COM) |=>
            (rdac_to_common_en == $past(reg_wdata[7])))
        else $error("common routing enable write not stored");

    chk_level_reset: assert property (
        $past(srst) |-> (common_hp_level == 4'h0 && rdac_to_common_vol == 7'h00))
        else $error("applied common gains not zero after reset");

    // one code per tick is what keeps big jumps free of zipper noise
    chk_level_one_step: assert property (
        tick |=> (common_hp_level == $past(common_hp_level)
            || common_hp_level == $past(common_hp_level) + 4'h1
            || common_hp_level == $past(common_hp_level) - 4'h1))
        else $error("common level jumped more than one code per tick");

    chk_vol_one_step: assert property (
        tick |=> (rdac_to_common_vol == $past(rdac_to_common_vol)
            || rdac_to_common_vol == $past(rdac_to_common_vol) + 7'h01
            || rdac_to_common_vol == $past(rdac_to_common_vol) - 7'h01))
        else $error("common routing volume jumped more than one code per tick");

    chk_page_gate: assert property (
        (reg_wr && !reg_page0) |=> ($stable(right_hp_route_en) && $stable(right_hp_vol)
            && $stable(rdac_to_common_en) && $stable(common_hp_unmute)))
        else $error("write on another page changed a register");
endmodule

// ==== test/hrr_headphone_regs_bench.sv ====
// Purpose: self-checking bench of the headphone output routing register bank
// Assumes: step pacing shortened to 4 cycles, inputs driven on the falling edge
// Notes:   every scenario task starts and ends at a falling edge
`timescale 1ns/1ps
`include "hrr_consts.svh"
module hrr_headphone_regs_bench import hrr_pkg::*;;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       clock     = 1'b0;
    logic       srst      = 1'b1;
    logic       reg_page0 = 1'b1;
    logic [6:0] reg_addr  = 7'h00;
    logic       reg_wr    = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       rdac_to_common_en;
    logic [6:0] rdac_to_common_vol;
    logic [3:0] common_hp_level;
    logic       common_hp_unmute;
    logic       common_hp_pd_hiz;
    logic       common_hp_power_up;
    logic       common_hp_pending;
    logic [4:0] right_hp_route_en;
    hrr_vol_t   right_hp_vol;
    int         bad_count  = 0;
    int         num_checks = 0;

    always #10 clock = ~clock;

    hrr_headphone_regs #(.STEP_CYCLES(16'h0004)) i_hrr_headphone_regs (
        .clock(clock), .srst(srst), .reg_page0(reg_page0), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rdac_to_common_en(rdac_to_common_en), .rdac_to_common_vol(rdac_to_common_vol),
        .common_hp_level(common_hp_level), .common_hp_unmute(common_hp_unmute),
        .common_hp_pd_hiz(common_hp_pd_hiz), .common_hp_power_up(common_hp_power_up),
        .common_hp_pending(common_hp_pending), .right_hp_route_en(right_hp_route_en),
        .right_hp_vol(right_hp_vol));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobe left high so that writes can follow back to back
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic pg = 1'b1);
        reg_page0 = pg;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
    endtask

    // read data is registered: it must stand one edge after the address
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic pg = 1'b1);
        reg_wr    = 1'b0;
        reg_page0 = pg;
        reg_addr  = a;
        @(negedge clock);
        check(reg_rdata, exp);
    endtask

    task automatic idle(input int n);
        reg_wr    = 1'b0;
        reg_page0 = 1'b1;
        repeat (n) @(negedge clock);
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // 0x3A must be read before the first step tick clears pending
    task automatic reset_defaults;
        srst   = 1'b1;
        reg_wr = 1'b0;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        check({7'h00, common_hp_pending}, 8'h01);
        rd(`HRR_IDX_COM_LEVEL, 8'h06);
        check({4'h0, common_hp_level}, 8'h00);
        check({5'h00, common_hp_unmute, common_hp_pd_hiz, common_hp_power_up}, 8'h02);
        check({3'h0, right_hp_route_en}, 8'h00);
        check({7'h00, rdac_to_common_en}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            check({1'b0, right_hp_vol[i]}, 8'h00);
            rd(`HRR_IDX_LAUX_TO_RHP + 7'(i), 8'h00);
        end
        rd(`HRR_IDX_RDAC_TO_COM, 8'h00);
        idle(10);
        rd(`HRR_IDX_COM_LEVEL, 8'h04);
    endtask

    task automatic right_routes;
        for (int i = 0; i < 5; i++) begin
            wr(`HRR_IDX_LAUX_TO_RHP + 7'(i), {i[0], 7'(8'h11 * (i + 1))});
        end
        wr(`HRR_IDX_RDAC_TO_COM, 8'h83);
        idle(1);
        check({3'h0, right_hp_route_en}, 8'h0A);
        check({7'h00, rdac_to_common_en}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            check({1'b0, right_hp_vol[i]}, 8'(8'h11 * (i + 1)));
            rd(`HRR_IDX_LAUX_TO_RHP + 7'(i), {i[0], 7'(8'h11 * (i + 1))});
        end
        idle(20);
        check({1'b0, rdac_to_common_vol}, 8'h03);
        rd(`HRR_IDX_RDAC_TO_COM, 8'h83);
    endtask

    // walks the level to the top code, pokes the status bit, then walks the level back down
    task automatic common_level;
        wr(`HRR_IDX_COM_LEVEL, 8'h99);
        rd(`HRR_IDX_COM_LEVEL, 8'h9B);
        idle(60);
        check({4'h0, common_hp_level}, 8'h09);
        check({4'h0, common_hp_unmute, common_hp_pd_hiz, common_hp_power_up,
               common_hp_pending}, 8'h0A);
        wr(`HRR_IDX_COM_LEVEL, 8'h9B);
        rd(`HRR_IDX_COM_LEVEL, 8'h99);
        wr(`HRR_IDX_COM_LEVEL, 8'h04);
        idle(60);
        check({4'h0, common_hp_level}, 8'h00);
        check({4'h0, common_hp_unmute, common_hp_pd_hiz, common_hp_power_up,
               common_hp_pending}, 8'h04);
    endtask

    task automatic gated_access;
        wr(`HRR_IDX_LAUX_TO_RHP, 8'hFF, 1'b0);
        wr(7'h40, 8'hFF);
        rd(`HRR_IDX_LAUX_TO_RHP, 8'h11);
        rd(`HRR_IDX_LAMP_TO_RHP, 8'h00, 1'b0);
        rd(7'h38, 8'h00);
        rd(7'h40, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        @(negedge clock);
        reset_defaults();
        right_routes();
        common_level();
        gated_access();
        reset_defaults();
        complete_run();
    end

    // run needs well under a thousand cycles
    initial begin
        #60000;
        bad_count++;
        complete_run();
    end

endmodule
